// ---- hw/wdm_defines.svh ----
`ifndef WDM_DEFINES_SVH
`define WDM_DEFINES_SVH

// register indices; byte address is four times the index
`define WDM_IDX_CTRL 3'h0
`define WDM_IDX_MOD 3'h2
`define WDM_IDX_COUNT 3'h4
`define WDM_IDX_SVC 3'h6

// control field positions
`define WDM_CTRL_EN 0
`define WDM_CTRL_HALT_STOP 1
`define WDM_CTRL_DOZE_STOP 2
`define WDM_CTRL_WAIT_STOP 3
`define WDM_CTRL_W 4

// reset values
`define WDM_RST_CTRL 4'hf
`define WDM_RST_MOD 16'hffff
`define WDM_RST_COUNT 16'hffff
`define WDM_RST_SVC 16'h0000

// service keys
`define WDM_KEY_FIRST 16'h5555
`define WDM_KEY_SECOND 16'haaaa

// prescaler: one count step per 4096 bus clocks
`define WDM_PRESCALE_LAST 12'hfff
`define WDM_PRESCALE_ZERO 12'h000

// avalon response codes and byte enables
`define WDM_RESP_OKAY 2'h0
`define WDM_RESP_SLVERR 2'h2
`define WDM_RESP_DECERR 2'h3
`define WDM_BE_WORD 4'hf

`endif

// ---- hw/wdm_pkg.sv ----
package wdm_pkg;

	// register bus slave phases
	typedef enum logic {
		bus_idle,
		bus_answer
	} wdm_bus_state_t;

endpackage

// ---- hw/wdm_ticker.sv ----
`timescale 1ns/1ns
`include "wdm_defines.svh"

// prescaled watchdog down-counter
module wdm_ticker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [15:0] load_value,
	input wire logic run,
	output logic [15:0] count,
	output logic [11:0] prescale
);

	// prescaler cleared on every load and on reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prescale <= `WDM_PRESCALE_ZERO;
		end else if (load) begin
			prescale <= `WDM_PRESCALE_ZERO;
		end else if (run) begin
			prescale <= prescale + 12'h001;
		end
	end

	// counter steps down once per prescaler wrap
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count <= `WDM_RST_COUNT;
		end else if (load) begin
			count <= load_value;
		end else if (run && prescale == `WDM_PRESCALE_LAST && count != 16'h0000) begin
			count <= count - 16'h0001;
		end
	end

	property p_tick_step;
		@(posedge core_clk) disable iff (!resetn)
		(run && !load && prescale == `WDM_PRESCALE_LAST && count != 16'h0000)
			|=> (count == $past(count) - 16'h0001 && prescale == `WDM_PRESCALE_ZERO);
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("count did not step on wrap");

	property p_no_early_step;
		@(posedge core_clk) disable iff (!resetn)
		(!load && prescale != `WDM_PRESCALE_LAST) |=> (count == $past(count));
	endproperty
	a_no_early_step: assert property (p_no_early_step) else $error("count moved mid-period");

	property p_load_clears_prescale;
		@(posedge core_clk) disable iff (!resetn)
		load |=> (prescale == `WDM_PRESCALE_ZERO && count == $past(load_value));
	endproperty
	a_load_clears_prescale: assert property (p_load_clears_prescale) else $error("load missed");

endmodule

// ---- hw/wdm_watchdog.sv ----
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "wdm_defines.svh"

// Functional notes
// - modulus copied into counter on service
// - modulus write-once except in halted mode
// - modulus write loads counter immediately
// - modulus read returns stored value
// - modulus resets to all ones
// - prescaler cleared on load and reset
// - counter steps once per 4096 clocks
// - count register reads live counter
// - count writes ignored, terminated normally
// - 0x5555 then 0xaaaa services the watchdog
// - expiry requests system reset
// - other traffic allowed between key writes
// - wrong key restarts service sequence
// - disable stops counting, never re-enables
// - halted stop pauses; halted writes stay open
// - wait and doze stop bits freeze timer
// - word access errors, byte/halfword accepted
module wdm_watchdog (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire logic halted_mode,
	input wire logic wait_mode,
	input wire logic doze_mode,
	output logic wdt_reset_req
);

	wdm_pkg::wdm_bus_state_t bus_state;
	logic [`WDM_CTRL_W-1:0] watchdog_control;
	logic ctrl_locked;
	logic [15:0] reload_modulus;
	logic mod_locked;
	logic [15:0] service_key;
	logic key_armed;
	logic [15:0] count;
	logic [11:0] prescale;

	logic [2:0] reg_idx;
	logic addr_ok;
	logic hit_ctrl;
	logic hit_mod;
	logic hit_count;
	logic hit_svc;
	logic word_access;
	logic [1:0] resp_now;
	logic [31:0] rd_value;
	logic commit_write;
	logic [15:0] merged_ctrl;
	logic [15:0] merged_mod;
	logic [15:0] merged_svc;
	logic ctrl_write_ok;
	logic mod_load;
	logic svc_write;
	logic svc_load;
	logic frozen;
	logic run;
	logic load;
	logic [15:0] load_value;

	// merge the two low byte lanes into a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old_value,
		input logic [31:0] data,
		input logic [3:0] be
	);
		logic [15:0] result;
		result[7:0] = be[0] ? data[7:0] : old_value[7:0];
		result[15:8] = be[1] ? data[15:8] : old_value[15:8];
		return result;
	endfunction

	// address decode; registers sit on word boundaries
	always_comb begin
		reg_idx = avs_address[4:2];
		hit_ctrl = (reg_idx == `WDM_IDX_CTRL);
		hit_mod = (reg_idx == `WDM_IDX_MOD);
		hit_count = (reg_idx == `WDM_IDX_COUNT);
		hit_svc = (reg_idx == `WDM_IDX_SVC);
		addr_ok = (avs_address[1:0] == 2'h0) && (hit_ctrl || hit_mod || hit_count || hit_svc);
		word_access = (avs_byteenable == `WDM_BE_WORD);
	end

	// answer code: decode error first, then the longword bus error
	always_comb begin
		if (!addr_ok) begin
			resp_now = `WDM_RESP_DECERR;
		end else if (word_access) begin
			resp_now = `WDM_RESP_SLVERR;
		end else begin
			resp_now = `WDM_RESP_OKAY;
		end
	end

	// read mux; upper lanes read as zero
	always_comb begin
		rd_value = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_value = {28'h000_0000, watchdog_control};
		end else if (hit_mod) begin
			rd_value = {16'h0000, reload_modulus};
		end else if (hit_count) begin
			rd_value = {16'h0000, count};
		end else if (hit_svc) begin
			rd_value = {16'h0000, service_key};
		end
	end

	// write effects happen at the edge where the master sees waitrequest low
	always_comb begin
		commit_write = (bus_state == wdm_pkg::bus_answer) && avs_write
			&& (resp_now == `WDM_RESP_OKAY);
		merged_ctrl = merge16({12'h000, watchdog_control}, avs_writedata, avs_byteenable);
		merged_mod = merge16(reload_modulus, avs_writedata, avs_byteenable);
		merged_svc = merge16(service_key, avs_writedata, avs_byteenable);
		ctrl_write_ok = commit_write && hit_ctrl && (!ctrl_locked || halted_mode);
		mod_load = commit_write && hit_mod && (!mod_locked || halted_mode);
		svc_write = commit_write && hit_svc;
		svc_load = svc_write && key_armed && (merged_svc == `WDM_KEY_SECOND);
	end

	// counter run gating and load selection
	always_comb begin
		frozen = (halted_mode && watchdog_control[`WDM_CTRL_HALT_STOP])
			|| (wait_mode && watchdog_control[`WDM_CTRL_WAIT_STOP])
			|| (doze_mode && watchdog_control[`WDM_CTRL_DOZE_STOP]);
		run = watchdog_control[`WDM_CTRL_EN] && !frozen && !wdt_reset_req;
		load = mod_load || svc_load;
		load_value = mod_load ? merged_mod : reload_modulus;
	end

	// avalon slave: one wait cycle, then the answer for one cycle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bus_state <= wdm_pkg::bus_idle;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			avs_response <= `WDM_RESP_OKAY;
		end else begin
			unique case (bus_state)
				wdm_pkg::bus_idle: begin
					if (avs_read || avs_write) begin
						bus_state <= wdm_pkg::bus_answer;
						avs_waitrequest <= 1'b0;
						avs_response <= resp_now;
						if (avs_read && resp_now == `WDM_RESP_OKAY) begin
							avs_readdata <= rd_value;
						end else begin
							avs_readdata <= 32'h0000_0000;
						end
					end
				end
				wdm_pkg::bus_answer: begin
					bus_state <= wdm_pkg::bus_idle;
					avs_waitrequest <= 1'b1;
					avs_readdata <= 32'h0000_0000;
					avs_response <= `WDM_RESP_OKAY;
				end
			endcase
		end
	end

	// control register: write-once outside halted mode, enable only falls
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			watchdog_control <= `WDM_RST_CTRL;
			ctrl_locked <= 1'b0;
		end else if (ctrl_write_ok) begin
			watchdog_control <= merged_ctrl[`WDM_CTRL_W-1:0];
			watchdog_control[`WDM_CTRL_EN] <= watchdog_control[`WDM_CTRL_EN]
				& merged_ctrl[`WDM_CTRL_EN];
			if (!halted_mode) begin
				ctrl_locked <= 1'b1;
			end
		end
	end

	// modulus register: write-once outside halted mode
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reload_modulus <= `WDM_RST_MOD;
			mod_locked <= 1'b0;
		end else if (mod_load) begin
			reload_modulus <= merged_mod;
			if (!halted_mode) begin
				mod_locked <= 1'b1;
			end
		end
	end

	// service key tracking; any stray value restarts the sequence
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			service_key <= `WDM_RST_SVC;
			key_armed <= 1'b0;
		end else if (svc_write) begin
			service_key <= merged_svc;
			if (svc_load) begin
				key_armed <= 1'b0;
			end else if (merged_svc == `WDM_KEY_FIRST) begin
				key_armed <= 1'b1;
			end else begin
				key_armed <= 1'b0;
			end
		end
	end

	// expiry request, held until system reset clears it
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wdt_reset_req <= 1'b0;
		end else if (run && !load && count == 16'h0000) begin
			wdt_reset_req <= 1'b1;
		end
	end

	// prescaled down-counter
	wdm_ticker u_ticker (
		.core_clk(core_clk),
		.resetn(resetn),
		.load(load),
		.load_value(load_value),
		.run(run),
		.count(count),
		.prescale(prescale)
	);

	sequence s_first_key;
		svc_write && merged_svc == `WDM_KEY_FIRST;
	endsequence

	sequence s_second_key;
		svc_write && merged_svc == `WDM_KEY_SECOND;
	endsequence

	property p_service_reload;
		@(posedge core_clk) disable iff (!resetn)
		(key_armed ##0 s_second_key) |=> (count == reload_modulus && !key_armed
			&& prescale == 12'h000);
	endproperty
	a_service_reload: assert property (p_service_reload) else $error("service did not reload");

	property p_first_key_arms;
		@(posedge core_clk) disable iff (!resetn)
		s_first_key |=> key_armed;
	endproperty
	a_first_key_arms: assert property (p_first_key_arms) else $error("first key not tracked");

	property p_bad_key_restarts;
		@(posedge core_clk) disable iff (!resetn)
		(svc_write && merged_svc != `WDM_KEY_FIRST && merged_svc != `WDM_KEY_SECOND)
			|=> !key_armed;
	endproperty
	a_bad_key_restarts: assert property (p_bad_key_restarts) else $error("stray key kept");

	property p_unarmed_second_ignored;
		@(posedge core_clk) disable iff (!resetn)
		(!key_armed && !mod_load) ##0 s_second_key |=> (count != reload_modulus
			|| $past(count) == reload_modulus || $past(prescale) == 12'hfff);
	endproperty
	a_unarmed_second_ignored: assert property (p_unarmed_second_ignored) else $error("lone key");

	property p_mod_write_loads;
		@(posedge core_clk) disable iff (!resetn)
		mod_load |=> (reload_modulus == count && reload_modulus == $past(merged_mod));
	endproperty
	a_mod_write_loads: assert property (p_mod_write_loads) else $error("modulus write lost");

	property p_mod_locked;
		@(posedge core_clk) disable iff (!resetn)
		(mod_locked && !halted_mode) |=> $stable(reload_modulus);
	endproperty
	a_mod_locked: assert property (p_mod_locked) else $error("locked modulus changed");

	property p_count_write_ignored;
		@(posedge core_clk) disable iff (!resetn)
		(commit_write && hit_count) |-> (avs_response == `WDM_RESP_OKAY && !load);
	endproperty
	a_count_write_ignored: assert property (p_count_write_ignored) else $error("count write");

	property p_word_error;
		@(posedge core_clk) disable iff (!resetn)
		(bus_state == wdm_pkg::bus_idle && (avs_read || avs_write) && addr_ok && word_access)
			|=> (!avs_waitrequest && avs_response == `WDM_RESP_SLVERR);
	endproperty
	a_word_error: assert property (p_word_error) else $error("longword not refused");

	property p_count_read;
		@(posedge core_clk) disable iff (!resetn)
		(bus_state == wdm_pkg::bus_idle && avs_read && hit_count && resp_now == 2'h0)
			|=> (avs_readdata[15:0] == $past(count) && avs_readdata[31:16] == 16'h0000);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	property p_disabled_stays;
		@(posedge core_clk) disable iff (!resetn)
		!watchdog_control[`WDM_CTRL_EN] |=> !watchdog_control[`WDM_CTRL_EN];
	endproperty
	a_disabled_stays: assert property (p_disabled_stays) else $error("watchdog re-enabled");

	property p_frozen_holds;
		@(posedge core_clk) disable iff (!resetn)
		(!run && !load) |=> ($stable(count) && $stable(prescale));
	endproperty
	a_frozen_holds: assert property (p_frozen_holds) else $error("stopped timer moved");

	property p_expiry;
		@(posedge core_clk) disable iff (!resetn)
		(run && !load && count == 16'h0000) |=> wdt_reset_req [*2];
	endproperty
	a_expiry: assert property (p_expiry) else $error("expiry not signalled");

	property p_req_cause;
		@(posedge core_clk) disable iff (!resetn)
		$rose(wdt_reset_req) |-> $past(count) == 16'h0000;
	endproperty
	a_req_cause: assert property (p_req_cause) else $error("request without expiry");

	// a locked control register only changes through halted-mode writes
	property p_ctrl_locked;
		@(posedge core_clk) disable iff (!resetn)
		(ctrl_locked && !halted_mode) |=> $stable(watchdog_control);
	endproperty
	a_ctrl_locked: assert property (p_ctrl_locked) else $error("locked control changed");

	// every bus answer lasts exactly one cycle
	property p_answer_once;
		@(posedge core_clk) disable iff (!resetn)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_answer_once: assert property (p_answer_once) else $error("answer held too long");

endmodule

// ---- tb/wdm_watchdog_bench.sv ----
`timescale 1ns/1ns
`include "wdm_defines.svh"

module wdm_watchdog_bench;
	localparam logic [4:0] a_ctrl = 5'h00;
	localparam logic [4:0] a_mod = 5'h08;
	localparam logic [4:0] a_cnt = 5'h10;
	localparam logic [4:0] a_svc = 5'h18;
	localparam logic [4:0] a_bad = 5'h04;
	logic core_clk, resetn, avs_read, avs_write, avs_waitrequest, wdt_reset_req;
	logic halted_mode, wait_mode, doze_mode;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [1:0] avs_response, rs;
	logic [15:0] rd, rd_hi;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	wdm_watchdog wdm_watchdog_i (.core_clk(core_clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .halted_mode(halted_mode), .wait_mode(wait_mode),
		.doze_mode(doze_mode), .wdt_reset_req(wdt_reset_req));

	// free-running clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic end_of_test();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// hang guard well above the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			$display("mismatch at %0t: run timed out", $time);
			end_of_test();
		end
	end

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: response %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: reset request %b expected %b", $time, got, exp);
		end
	endtask

	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= be;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			num_errors++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		rd = avs_readdata[15:0];
		rd_hi = avs_readdata[31:16];
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		bus(1'b1, a, d, 4'h3);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
		bus(1'b0, a, 16'h0000, 4'h3);
		chk_val(rd, exp);
		chk_val(rd_hi, 16'h0000);
	endtask

	task automatic pause(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic do_reset();
		resetn <= 1'b0;
		pause(2);
		resetn <= 1'b1;
	endtask

	task automatic t_reset_values();
		rd_chk(a_ctrl, `WDM_RST_CTRL);
		rd_chk(a_mod, `WDM_RST_MOD);
		rd_chk(a_cnt, `WDM_RST_COUNT);
		chk_flag(wdt_reset_req, 1'b0);
	endtask

	// halted writes load at once and leave the counter paused
	task automatic t_halted_load();
		halted_mode <= 1'b1;
		wr(a_mod, 16'h0003);
		chk_resp(rs, `WDM_RESP_OKAY);
		rd_chk(a_mod, 16'h0003);
		rd_chk(a_cnt, 16'h0003);
		pause(5000);
		rd_chk(a_cnt, 16'h0003);
		halted_mode <= 1'b0;
		pause(4200);
		rd_chk(a_cnt, 16'h0002);
	endtask

	task automatic t_lock();
		wr(a_mod, 16'h0007);
		rd_chk(a_cnt, 16'h0007);
		wr(a_mod, 16'h0009);
		rd_chk(a_mod, 16'h0007);
	endtask

	task automatic t_service();
		pause(4200);
		rd_chk(a_cnt, 16'h0006);
		wr(a_svc, `WDM_KEY_FIRST);
		rd_chk(a_mod, 16'h0007);
		wr(a_svc, `WDM_KEY_SECOND);
		rd_chk(a_cnt, 16'h0007);
		pause(4030);
		rd_chk(a_cnt, 16'h0007);
		pause(200);
		rd_chk(a_cnt, 16'h0006);
	endtask

	task automatic t_bad_sequence();
		wr(a_svc, `WDM_KEY_FIRST);
		wr(a_svc, 16'h1234);
		wr(a_svc, `WDM_KEY_SECOND);
		rd_chk(a_cnt, 16'h0006);
		wr(a_svc, `WDM_KEY_SECOND);
		rd_chk(a_cnt, 16'h0006);
		wr(a_svc, `WDM_KEY_FIRST);
		wr(a_svc, `WDM_KEY_SECOND);
		rd_chk(a_cnt, 16'h0007);
	endtask

	task automatic t_refusals();
		wr(a_cnt, 16'h0000);
		chk_resp(rs, `WDM_RESP_OKAY);
		rd_chk(a_cnt, 16'h0007);
		bus(1'b1, a_svc, `WDM_KEY_FIRST, `WDM_BE_WORD);
		chk_resp(rs, `WDM_RESP_SLVERR);
		bus(1'b0, a_bad, 16'h0000, 4'h3);
		chk_resp(rs, `WDM_RESP_DECERR);
	endtask

	task automatic t_low_power();
		wait_mode <= 1'b1;
		pause(4200);
		rd_chk(a_cnt, 16'h0007);
		wait_mode <= 1'b0;
		doze_mode <= 1'b1;
		pause(4200);
		rd_chk(a_cnt, 16'h0007);
		doze_mode <= 1'b0;
	endtask

	task automatic t_expiry();
		do_reset();
		wr(a_mod, 16'h0001);
		pause(4000);
		chk_flag(wdt_reset_req, 1'b0);
		pause(200);
		chk_flag(wdt_reset_req, 1'b1);
		pause(20);
		chk_flag(wdt_reset_req, 1'b1);
	endtask

	task automatic t_disable();
		do_reset();
		wr(a_ctrl, 16'h000e);
		pause(4200);
		rd_chk(a_cnt, `WDM_RST_COUNT);
		halted_mode <= 1'b1;
		wr(a_ctrl, 16'h000f);
		rd_chk(a_ctrl, 16'h000e);
		halted_mode <= 1'b0;
	endtask

	// main sequence
	initial begin
		resetn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		halted_mode = 1'b0;
		wait_mode = 1'b0;
		doze_mode = 1'b0;
		do_reset();
		t_reset_values();
		t_halted_load();
		t_lock();
		t_service();
		t_bad_sequence();
		t_refusals();
		t_low_power();
		t_expiry();
		t_disable();
		end_of_test();
	end
endmodule
